// *** rtl/mgmt_cfg.svh ***
// Constants for the module management block: timing, offsets, fields
`ifndef MGMT_CFG_SVH
`define MGMT_CFG_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_MHZ          25
`define US_NS            1000
`define CYC_PER_US       ((`US_NS * `CLK_MHZ) / 1000)
`define RESET_MIN_NS     2000
`define RESET_MIN_CYC    ((`RESET_MIN_NS * `CLK_MHZ + 999) / 1000)
`define INIT_US_DEFAULT  1000

// ****************************************************************
// Serial responder
// ****************************************************************
`define SERIAL_ADDR      7'h50
`define LANES            4

// ****************************************************************
// Lower page offsets and fields
// ****************************************************************
`define A_STATUS         8'h02
`define A_LOS_FLAG       8'h03
`define A_FAULT_FLAG     8'h04
`define A_MOD_STATE      8'h06
`define A_PWR_CTRL       8'h5d
`define A_LOS_MASK       8'h64
`define A_FAULT_MASK     8'h65
`define A_PAGE_SEL       8'h7f
`define UPPER_BIT        7
`define DNR_BIT          0
`define PDOWN_BIT        0
`define ID_PAGE          8'h00

`endif

// *** rtl/mgmt_if.sv ***
// Byte access path from the serial responder to the register map
`default_nettype none
interface mgmt_if;
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic        enable;

    modport target (output wr, rd, addr, wdata, input rdata, enable);
    modport regs   (input wr, rd, addr, wdata, output rdata, enable);
endinterface
`default_nettype wire

// *** rtl/mgmt_pkg.sv ***
// Types shared by the module management block
`default_nettype none
package mgmt_pkg;

    typedef logic [7:0] byte_t;

    typedef enum logic [8:0] {
        ST_IDLE   = 9'h001,
        ST_ADDR   = 9'h002,
        ST_ACK_A  = 9'h004,
        ST_WRITE  = 9'h008,
        ST_ACK_W  = 9'h010,
        ST_RWAIT  = 9'h020,
        ST_READ   = 9'h040,
        ST_RACK   = 9'h080,
        ST_RFETCH = 9'h100
    } serial_state_e;

    typedef enum logic [2:0] {
        RS_HOLD = 3'h1,
        RS_INIT = 3'h2,
        RS_RUN  = 3'h4
    } reset_state_e;

endpackage
`default_nettype wire

// *** rtl/module_mgmt_control_timing.sv ***
// Management and control logic of a pluggable optical module
//
// Chosen here: the address map and the address-and-strobe port.
`include "mgmt_cfg.svh"
`default_nettype none
module module_mgmt_control_timing #(
    parameter int unsigned INIT_US = `INIT_US_DEFAULT
) (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       reset_n_in,
    input  wire logic       module_select_n,
    input  wire logic       low_power_request,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_n,
    input  wire logic [3:0] rx_los_in,
    input  wire logic [3:0] tx_fault_in,
    output logic            irq_n_out,
    output logic            present_n_out,
    output logic            low_power_out,
    output logic            fully_functional,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic [7:0]      reg_rdata
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    localparam int PINS = 5 + 2 * `LANES;

    logic [PINS-1:0] pin_raw;
    logic [PINS-1:0] pin_meta;
    logic [PINS-1:0] pin_sync;
    logic [3:0]      tx_fault_s;
    logic [3:0]      rx_los_s;
    logic            sda_s;
    logic            scl_s;
    logic            lp_s;
    logic            sel_n_s;
    logic            rst_n_s;

    assign pin_raw = {tx_fault_in, rx_los_in, sda_in, scl_in,
                      low_power_request, module_select_n, reset_n_in};

    for (genvar i = 0; i < PINS; i++) begin : g_sync
        always_ff @(posedge clk) begin
            pin_meta[i] <= pin_raw[i];
            pin_sync[i] <= pin_meta[i];
        end
    end

    assign {tx_fault_s, rx_los_s, sda_s, scl_s, lp_s, sel_n_s, rst_n_s} =
        pin_sync;

    // ************************************************************
    // Time base
    // ************************************************************
    logic us_tick;

    us_tick_gen u_tick (
        .clk  (clk),
        .srst (srst),
        .tick (us_tick)
    );

    // ************************************************************
    // Reset pin filter and initialisation sequence
    // ************************************************************
    mgmt_pkg::reset_state_e rst_state;
    logic [5:0]  low_cnt;
    logic [20:0] init_cnt;
    logic        pin_reset;
    logic        in_hold;
    logic        init_done;

    // Glitches shorter than the minimum pulse never reach the logic
    always_ff @(posedge clk) begin
        if (srst || rst_n_s) begin
            low_cnt <= 6'h00;
        end else if (low_cnt != 6'(`RESET_MIN_CYC)) begin
            low_cnt <= low_cnt + 6'h01;
        end
    end

    assign pin_reset = (low_cnt == 6'(`RESET_MIN_CYC));
    assign in_hold   = (rst_state == mgmt_pkg::RS_HOLD);
    assign init_done = (rst_state == mgmt_pkg::RS_INIT) && us_tick &&
                       (init_cnt == 21'(INIT_US - 1));

    // Power-on and hot plug both arrive here as the system reset
    always_ff @(posedge clk) begin
        if (srst) begin
            rst_state <= mgmt_pkg::RS_INIT;
            init_cnt  <= 21'h000000;
        end else if (pin_reset) begin
            rst_state <= mgmt_pkg::RS_HOLD;
            init_cnt  <= 21'h000000;
        end else begin
            case (rst_state)
                mgmt_pkg::RS_HOLD: begin
                    if (rst_n_s) begin
                        rst_state <= mgmt_pkg::RS_INIT;
                    end
                end
                mgmt_pkg::RS_INIT: begin
                    if (init_done) begin
                        rst_state <= mgmt_pkg::RS_RUN;
                    end else if (us_tick) begin
                        init_cnt <= init_cnt + 21'h000001;
                    end
                end
                mgmt_pkg::RS_RUN: begin
                    rst_state <= mgmt_pkg::RS_RUN;
                end
                default: begin
                    rst_state <= mgmt_pkg::RS_HOLD;
                end
            endcase
        end
    end

    // ************************************************************
    // Serial responder
    // ************************************************************
    mgmt_if host ();
    logic serial_en;
    logic sda_drive;

    // Answers as soon as the pin reset is over; selection is a few
    // clocks of synchroniser delay, far inside the limit
    always_ff @(posedge clk) begin
        if (srst) begin
            serial_en <= 1'b0;
        end else begin
            serial_en <= !in_hold && !sel_n_s;
        end
    end

    assign host.enable = serial_en;

    serial_target u_target (
        .clk       (clk),
        .srst      (srst),
        .scl       (scl_s),
        .sda       (sda_s),
        .drive_low (sda_drive),
        .bus       (host)
    );

    // Open drain: only ever pulls low
    always_ff @(posedge clk) begin
        if (srst) begin
            sda_out  <= 1'b0;
            sda_oe_n <= 1'b1;
        end else begin
            sda_out  <= 1'b0;
            sda_oe_n <= !sda_drive;
        end
    end

    // ************************************************************
    // Control and mask registers
    // ************************************************************
    logic [3:0] los_mask;
    logic [3:0] fault_mask;
    logic       p_down;
    logic [7:0] page_sel;

    // Host writes win over a same-cycle local write to one register
    always_ff @(posedge clk) begin
        if (srst || in_hold) begin
            los_mask   <= 4'h0;
            fault_mask <= 4'h0;
            p_down     <= 1'b0;
            page_sel   <= 8'h00;
        end else begin
            if (host.wr && host.addr == `A_LOS_MASK) begin
                los_mask <= host.wdata[3:0];
            end else if (reg_wr && reg_addr == `A_LOS_MASK) begin
                los_mask <= reg_wdata[3:0];
            end
            if (host.wr && host.addr == `A_FAULT_MASK) begin
                fault_mask <= host.wdata[3:0];
            end else if (reg_wr && reg_addr == `A_FAULT_MASK) begin
                fault_mask <= reg_wdata[3:0];
            end
            if (host.wr && host.addr == `A_PWR_CTRL) begin
                p_down <= host.wdata[`PDOWN_BIT];
            end else if (reg_wr && reg_addr == `A_PWR_CTRL) begin
                p_down <= reg_wdata[`PDOWN_BIT];
            end
            if (host.wr && host.addr == `A_PAGE_SEL) begin
                page_sel <= host.wdata;
            end else if (reg_wr && reg_addr == `A_PAGE_SEL) begin
                page_sel <= reg_wdata;
            end
        end
    end

    // ************************************************************
    // Upper page identification memory
    // ************************************************************
    // Loaded locally only; the host sees it read-only through paging
    mgmt_pkg::byte_t id_mem [0:127];

    always_ff @(posedge clk) begin
        if (reg_wr && reg_addr[`UPPER_BIT] && page_sel == `ID_PAGE) begin
            id_mem[reg_addr[6:0]] <= reg_wdata;
        end
    end

    // ************************************************************
    // Flags, status and interrupt
    // ************************************************************
    logic [3:0] los_flag;
    logic [3:0] fault_flag;
    logic       init_flag;
    logic       dnr;
    logic       clr_los;
    logic       clr_fault;
    logic       clr_init;
    logic       low_power;

    assign clr_los   = host.rd && host.addr == `A_LOS_FLAG;
    assign clr_fault = host.rd && host.addr == `A_FAULT_FLAG;
    assign clr_init  = host.rd && host.addr == `A_STATUS;
    assign low_power = lp_s || p_down;

    // A condition present in the clearing cycle sets its flag again
    always_ff @(posedge clk) begin
        if (srst || in_hold) begin
            los_flag   <= 4'h0;
            fault_flag <= 4'h0;
            init_flag  <= 1'b0;
        end else begin
            los_flag   <= (clr_los ? 4'h0 : los_flag) | rx_los_s;
            fault_flag <= (clr_fault ? 4'h0 : fault_flag) |
                          tx_fault_s;
            init_flag  <= (clr_init ? 1'b0 : init_flag) | init_done;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || in_hold) begin
            dnr <= 1'b1;
        end else if (init_done) begin
            dnr <= 1'b0;
        end
    end

    // Unmasked flags reach the pin one clock after they change
    always_ff @(posedge clk) begin
        if (srst || in_hold) begin
            irq_n_out <= 1'b1;
        end else begin
            irq_n_out <= !(init_flag || |(los_flag & ~los_mask) ||
                           |(fault_flag & ~fault_mask));
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            low_power_out    <= 1'b0;
            fully_functional <= 1'b0;
            present_n_out    <= 1'b0;
        end else begin
            low_power_out    <= low_power;
            fully_functional <= !dnr && !low_power;
            present_n_out    <= 1'b0;
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    function automatic mgmt_pkg::byte_t read_byte(input logic [7:0] a);
        mgmt_pkg::byte_t v;
        v = 8'h00;
        if (a[`UPPER_BIT]) begin
            if (page_sel == `ID_PAGE) begin
                v = id_mem[a[6:0]];
            end
        end else if (a == `A_STATUS) begin
            v[`DNR_BIT] = dnr;
        end else if (a == `A_LOS_FLAG) begin
            v[3:0] = los_flag;
        end else if (a == `A_FAULT_FLAG) begin
            v[3:0] = fault_flag;
        end else if (a == `A_MOD_STATE) begin
            v[3:0] = {!sel_n_s, serial_en, !dnr, low_power};
        end else if (a == `A_PWR_CTRL) begin
            v[`PDOWN_BIT] = p_down;
        end else if (a == `A_LOS_MASK) begin
            v[3:0] = los_mask;
        end else if (a == `A_FAULT_MASK) begin
            v[3:0] = fault_mask;
        end else if (a == `A_PAGE_SEL) begin
            v = page_sel;
        end
        return v;
    endfunction

    always_ff @(posedge clk) begin
        if (srst) begin
            host.rdata <= 8'h00;
        end else if (host.rd) begin
            host.rdata <= read_byte(host.addr);
        end
    end

    // Local reads leave the flags alone so the host still sees them
    always_ff @(posedge clk) begin
        if (srst || !reg_rd) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= read_byte(reg_addr);
        end
    end

endmodule
`default_nettype wire

// *** rtl/serial_target.sv ***
// Two-wire serial responder: address match, byte pointer, read and write
`include "mgmt_cfg.svh"
`default_nettype none
module serial_target (
    input  wire logic      clk,
    input  wire logic      srst,
    input  wire logic      scl,
    input  wire logic      sda,
    output logic           drive_low,
    mgmt_if.target         bus
);
    mgmt_pkg::serial_state_e state;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic [3:0] bitcnt;
    logic       scl_q;
    logic       sda_q;
    logic       have_ptr;
    logic       inc;
    logic       rise;
    logic       fall;
    logic       start;
    logic       stop;

    assign rise  = scl & ~scl_q;
    assign fall  = ~scl & scl_q;
    assign start = scl & scl_q & sda_q & ~sda;
    assign stop  = scl & scl_q & ~sda_q & sda;
    assign bus.addr = ptr;

    always_ff @(posedge clk) begin
        scl_q <= scl;
        sda_q <= sda;
    end

    // Deselect drops any transfer at once and releases the data line
    always_ff @(posedge clk) begin
        bus.wr <= 1'b0;
        bus.rd <= 1'b0;
        if (srst || !bus.enable) begin
            state     <= mgmt_pkg::ST_IDLE;
            drive_low <= 1'b0;
            bitcnt    <= 4'h0;
            shreg     <= 8'h00;
            have_ptr  <= 1'b0;
            inc       <= 1'b0;
            bus.wdata <= 8'h00;
            if (srst) begin
                ptr <= 8'h00;
            end
        end else if (start) begin
            state     <= mgmt_pkg::ST_ADDR;
            bitcnt    <= 4'h0;
            drive_low <= 1'b0;
        end else if (stop) begin
            state     <= mgmt_pkg::ST_IDLE;
            drive_low <= 1'b0;
        end else begin
            case (state)
                mgmt_pkg::ST_ADDR: begin
                    if (rise) begin
                        shreg  <= {shreg[6:0], sda};
                        bitcnt <= bitcnt + 4'h1;
                    end else if (fall && bitcnt == 4'h8) begin
                        if (shreg[7:1] == `SERIAL_ADDR) begin
                            drive_low <= 1'b1;
                            if (shreg[0]) begin
                                bus.rd <= 1'b1;
                                state  <= mgmt_pkg::ST_RWAIT;
                            end else begin
                                state <= mgmt_pkg::ST_ACK_A;
                            end
                        end else begin
                            state <= mgmt_pkg::ST_IDLE;
                        end
                    end
                end
                mgmt_pkg::ST_ACK_A: begin
                    if (fall) begin
                        drive_low <= 1'b0;
                        bitcnt    <= 4'h0;
                        have_ptr  <= 1'b0;
                        state     <= mgmt_pkg::ST_WRITE;
                    end
                end
                mgmt_pkg::ST_WRITE: begin
                    if (rise) begin
                        shreg  <= {shreg[6:0], sda};
                        bitcnt <= bitcnt + 4'h1;
                    end else if (fall && bitcnt == 4'h8) begin
                        drive_low <= 1'b1;
                        state     <= mgmt_pkg::ST_ACK_W;
                        inc       <= have_ptr;
                        have_ptr  <= 1'b1;
                        if (have_ptr) begin
                            bus.wr    <= 1'b1;
                            bus.wdata <= shreg;
                        end else begin
                            ptr <= shreg;
                        end
                    end
                end
                mgmt_pkg::ST_ACK_W: begin
                    if (fall) begin
                        drive_low <= 1'b0;
                        bitcnt    <= 4'h0;
                        state     <= mgmt_pkg::ST_WRITE;
                        if (inc) begin
                            ptr <= ptr + 8'h01;
                        end
                    end
                end
                mgmt_pkg::ST_RWAIT: begin
                    if (fall) begin
                        shreg     <= bus.rdata;
                        drive_low <= ~bus.rdata[7];
                        bitcnt    <= 4'h0;
                        state     <= mgmt_pkg::ST_READ;
                    end
                end
                mgmt_pkg::ST_READ: begin
                    if (fall) begin
                        if (bitcnt == 4'h7) begin
                            drive_low <= 1'b0;
                            state     <= mgmt_pkg::ST_RACK;
                        end else begin
                            shreg     <= {shreg[6:0], 1'b0};
                            drive_low <= ~shreg[6];
                            bitcnt    <= bitcnt + 4'h1;
                        end
                    end
                end
                mgmt_pkg::ST_RACK: begin
                    if (rise) begin
                        ptr   <= ptr + 8'h01;
                        state <= sda ? mgmt_pkg::ST_IDLE
                                     : mgmt_pkg::ST_RFETCH;
                    end
                end
                mgmt_pkg::ST_RFETCH: begin
                    bus.rd <= 1'b1;
                    state  <= mgmt_pkg::ST_RWAIT;
                end
                default: begin
                    state <= mgmt_pkg::ST_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// *** rtl/us_tick_gen.sv ***
// One-microsecond enable pulse divided from the system clock
`include "mgmt_cfg.svh"
`default_nettype none
module us_tick_gen (
    input  wire logic clk,
    input  wire logic srst,
    output logic      tick
);
    logic [4:0] cnt;

    always_ff @(posedge clk) begin
        if (srst) begin
            cnt  <= 5'h00;
            tick <= 1'b0;
        end else if (cnt == 5'(`CYC_PER_US - 1)) begin
            cnt  <= 5'h00;
            tick <= 1'b1;
        end else begin
            cnt  <= cnt + 5'h01;
            tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** tb/mgmt_host_model.sv ***
// Host side of the two-wire bus: start, 9-bit slots, stop
`include "mgmt_cfg.svh"
`default_nettype none
module mgmt_host_model (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_drv
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [8:0] r;
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // Quarter bit of 80 ns; data moves while clock is high only for start and stop
    task automatic st(input logic c, input logic d);
        repeat (2) @(posedge clk);
        scl <= c;
        sda_drv <= d;
    endtask
    task automatic start();
        st(0, 1);
        st(1, 1);
        st(1, 0);
        st(0, 0);
    endtask
    task automatic xb(input logic [8:0] b);
        for (int i = 8; i >= 0; i--) begin
            st(0, b[i]);
            st(1, b[i]);
            st(1, b[i]);
            r[i] = sda;
            st(0, b[i]);
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output logic ack);
        start();
        xb({`SERIAL_ADDR, 2'b01});
        ack = r[0];
        xb({a, 1'b1});
        start();
        xb({`SERIAL_ADDR, 2'b11});
        xb(9'h1ff);
        d = r[8:1];
        st(0, 0);
        st(1, 0);
        st(1, 1);
    endtask
    task automatic wr(input logic [7:0] a, d);
        start();
        xb({`SERIAL_ADDR, 2'b01});
        xb({a, 1'b1});
        xb({d, 1'b1});
        st(0, 0);
        st(1, 0);
        st(1, 1);
    endtask
endmodule
`default_nettype wire

// *** tb/module_mgmt_control_timing_sva.sv ***
// Checker of pin timing of the management block
`default_nettype none
module module_mgmt_control_timing_sva #(
    parameter int unsigned INIT_US = 2
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic reset_n_in,
    input wire logic module_select_n,
    input wire logic low_power_request,
    input wire logic irq_n_out,
    input wire logic present_n_out,
    input wire logic low_power_out,
    input wire logic fully_functional,
    input wire logic sda_oe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    // Slack covers tick phase, synchronisers and output register
    localparam int RUN_N = INIT_US * 25 + 10;
    logic [15:0] run;
    logic [5:0]  low;
    always_ff @(posedge clk) begin
        if (srst || !reset_n_in) run <= '0;
        else if (run != '1) run <= run + 16'h0001;
    end
    always_ff @(posedge clk) begin
        if (srst || reset_n_in) low <= '0;
        else if (low != '1) low <= low + 6'h01;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    rst_irq_a: assert property (disable iff (1'b0)
        srst |=> irq_n_out) else $error("irq active in reset");
    rst_pins_a: assert property (disable iff (1'b0)
        srst |=> sda_oe_n && !low_power_out) else $error("pins in reset");
    present_low_a: assert property (!present_n_out)
        else $error("present released");
    init_irq_a: assert property (run == RUN_N |->
        !irq_n_out && (fully_functional || low_power_out))
        else $error("init late");
    pin_hold_a: assert property (low == 6'd60 |->
        irq_n_out && sda_oe_n) else $error("reset pin ignored");
    lp_enter_a: assert property ($rose(low_power_request) |->
        ##[1:8] low_power_out) else $error("low power late");
    lp_func_a: assert property (low_power_out |->
        !fully_functional) else $error("functional in low power");
    desel_quiet_a: assert property (module_select_n [*8] |->
        sda_oe_n) else $error("drives when deselected");
    cover property ($rose(low_power_out));
    cover property ($fell(sda_oe_n));
    cover property ($rose(irq_n_out));
endmodule
bind module_mgmt_control_timing module_mgmt_control_timing_sva #(
    .INIT_US(INIT_US)
) i_module_mgmt_control_timing_sva (
    .clk(clk), .srst(srst), .reset_n_in(reset_n_in),
    .module_select_n(module_select_n), .irq_n_out(irq_n_out),
    .low_power_request(low_power_request), .sda_oe_n(sda_oe_n),
    .present_n_out(present_n_out), .low_power_out(low_power_out),
    .fully_functional(fully_functional));
`default_nettype wire

// *** tb/module_mgmt_control_timing_tb.sv ***
// Bench: pins, local registers and host reads of the management block
`include "mgmt_cfg.svh"
`default_nettype none
module module_mgmt_control_timing_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk = 0;
    logic       srst = 1;
    logic       reset_n_in = 1;
    logic       module_select_n = 1;
    logic       low_power_request = 0;
    logic       scl, sda_drv, sda_oe_n, sda_out, sda, ack;
    logic [3:0] rx_los_in = 0;
    logic [3:0] tx_fault_in = 0;
    logic       irq_n_out, fully_functional, low_power_out;
    logic [7:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0;
    logic       reg_wr = 0;
    logic       reg_rd = 0;
    logic [7:0] reg_rdata, v, e;
    int         bad_count = 0;
    int         compares = 0;
    always #20 clk = ~clk;
    assign sda = sda_drv & (sda_oe_n | sda_out);
    module_mgmt_control_timing #(.INIT_US(2))
        i_module_mgmt_control_timing (
        .clk(clk), .srst(srst), .reset_n_in(reset_n_in),
        .module_select_n(module_select_n), .scl_in(scl),
        .low_power_request(low_power_request), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .rx_los_in(rx_los_in),
        .tx_fault_in(tx_fault_in), .irq_n_out(irq_n_out),
        .present_n_out(), .low_power_out(low_power_out),
        .fully_functional(fully_functional), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata));
    mgmt_host_model i_mgmt_host_model (.clk(clk), .sda(sda), .scl(scl),
        .sda_drv(sda_drv));
    task automatic check(input string n, input logic [7:0] s, x);
        compares++;
        if (s !== x) begin
            bad_count++;
            $display("MISMATCH %s exp %h seen %h", n, x, s);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1;
        @(posedge clk);
        reg_wr <= 0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1;
        @(posedge clk);
        reg_rd <= 0;
        @(posedge clk);
        v = reg_rdata;
    endtask
    task automatic end_sim();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #2ms;
        bad_count++;
        end_sim();
    end
    initial begin
        wt(16);
        srst <= 0;
        rd(`A_STATUS);
        check("dnr", v & 8'h01, 8'h01);
        wt(80);
        check("irq", irq_n_out, 0);
        check("ff", fully_functional, 1);
        rd(`A_STATUS);
        check("dnr", v & 8'h01, 8'h00);
        rd(8'h10);
        check("unmapped", v, 8'h00);
        module_select_n <= 0;
        wt(10);
        i_mgmt_host_model.rd(`A_STATUS, v, ack);
        check("ack", ack, 0);
        wt(20);
        check("irq", irq_n_out, 1);
        for (int k = 0; k < 2; k++) begin
            {tx_fault_in, rx_los_in} <= k ? 8'h80 : 8'h01;
            e = k ? 8'h08 : 8'h01;
            wt(10);
            check("irq", irq_n_out, 0);
            rd(`A_LOS_FLAG + 8'(k));
            check("flag", v & 8'h0f, e);
            wr(`A_LOS_MASK + 8'(k), e);
            wt(5);
            check("masked", irq_n_out, 1);
            wr(`A_LOS_MASK + 8'(k), 8'h00);
            wt(5);
            check("unmasked", irq_n_out, 0);
            {tx_fault_in, rx_los_in} <= 8'h00;
            wt(5);
            i_mgmt_host_model.rd(`A_LOS_FLAG + 8'(k), v, ack);
            check("flag", v & 8'h0f, e);
            wt(20);
            check("irq", irq_n_out, 1);
        end
        low_power_request <= 1;
        wt(10);
        check("lp", low_power_out, 1);
        check("ff", fully_functional, 0);
        low_power_request <= 0;
        i_mgmt_host_model.wr(`A_PWR_CTRL, 8'h01);
        wt(10);
        check("pdown", low_power_out, 1);
        wr(`A_PWR_CTRL, 8'h00);
        wt(10);
        check("ff", fully_functional, 1);
        module_select_n <= 1;
        wt(10);
        i_mgmt_host_model.rd(`A_STATUS, v, ack);
        check("ack", ack, 1);
        wr(`A_LOS_MASK, 8'h05);
        rx_los_in <= 4'h2;
        reset_n_in <= 0;
        wt(60);
        reset_n_in <= 1;
        rx_los_in <= 4'h0;
        wt(4);
        check("irq", irq_n_out, 1);
        rd(`A_LOS_MASK);
        check("mask", v, 8'h00);
        wt(80);
        check("irq", irq_n_out, 0);
        end_sim();
    end
endmodule
`default_nettype wire
